// File: flash_bus_cycle.sv
// Purpose: runs one asynchronous flash bus read or write on the pins
// Assumes: 100 ns clock period, flash access well under one period
// Notes: read data pass two flops before capture
`timescale 1ns/100ps
module flash_bus_cycle
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_sync_b,
  // sequencer side
  flash_cyc_if.eng cyc,
  // flash pins
  output logic [21:0] f_addr,
  output logic f_ce_b,
  output logic f_oe_b,
  output logic f_we_b,
  output logic [15:0] f_dq_o,
  output logic f_dq_oe,
  input wire logic [15:0] f_dq_i
);
`include "flash_host_map.svh"

  cyc_regs_t q, d;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.s1 = f_dq_i;
    d.s2 = q.s1;
    case (q.st)
      C_IDLE:
      begin
        if (cyc.req)
        begin
          d.a = cyc.addr;
          d.ce_b = 1'b0;
          d.cnt = 2'h0;
          if (cyc.wr)
          begin
            // oe stays high, so the write is never inhibited
            d.dq_o = cyc.wdata;
            d.dq_oe = 1'b1;
            d.st = C_W_LOW;
          end
          else
          begin
            d.oe_b = 1'b0;
            d.st = C_R_WAIT;
          end
        end
      end
      C_W_LOW:
      begin
        d.we_b = 1'b0;
        d.st = C_W_HIGH;
      end
      C_W_HIGH:
      begin
        // data latch on this rising edge of we
        d.we_b = 1'b1;
        d.st = C_W_END;
      end
      C_W_END:
      begin
        d.ce_b = 1'b1;
        d.dq_oe = 1'b0;
        d.done = 1'b1;
        d.st = C_IDLE;
      end
      C_R_WAIT:
      begin
        d.cnt = q.cnt + 2'h1;
        if (q.cnt == `RD_WAIT_LAST)
        begin
          d.rdata = q.s2;
          d.ce_b = 1'b1;
          d.oe_b = 1'b1;
          d.done = 1'b1;
          d.st = C_IDLE;
        end
      end
      default: d.st = C_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      q <= '0;
      q.st <= C_IDLE;
      q.ce_b <= 1'b1;
      q.oe_b <= 1'b1;
      q.we_b <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign f_addr = q.a;
  assign f_ce_b = q.ce_b;
  assign f_oe_b = q.oe_b;
  assign f_we_b = q.we_b;
  assign f_dq_o = q.dq_o;
  assign f_dq_oe = q.dq_oe;
  assign cyc.done = q.done;
  assign cyc.rdata = q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_b);

  sequence write_strobe_s;
    ##1 !f_ce_b && f_we_b ##1 !f_we_b ##1 f_we_b ##1 f_ce_b && cyc.done;
  endsequence

  chk_write_pins: assert property (!f_we_b |-> !f_ce_b && f_oe_b && f_dq_oe)
    else $error("write strobe low without chip select or with output gate low");
  chk_write_steps: assert property (q.st == C_IDLE && cyc.req && cyc.wr |-> write_strobe_s)
    else $error("write cycle did not follow select, strobe, release order");
  chk_read_done: assert property (q.st == C_IDLE && cyc.req && !cyc.wr |-> f_we_b [*5] ##1 cyc.done)
    else $error("read cycle length wrong or write strobe moved");
endmodule : flash_bus_cycle

// File: flash_cyc_if.sv
// Purpose: request and answer between the sequencer and the bus cycle engine
// Assumes: one request outstanding at a time
// Notes: req and done are one-cycle pulses
`timescale 1ns/100ps
interface flash_cyc_if;
  logic req;
  logic wr;
  logic [21:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport ctl (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : flash_cyc_if

// File: flash_dev_model.sv
// Purpose: behavioural flash device on the far side of the host pins
// Assumes: pins change only on host clock edges
// Notes: addr bit 21 marks a protected sector; released data lines show the inverse of the last word
`timescale 1ns/100ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int BUSY_READS = 3
)
(
  // host pins
  input wire flash_host_pkg::faddr_t a,
  input wire logic ce_b,
  input wire logic oe_b,
  input wire logic we_b,
  input wire flash_host_pkg::fdata_t din,
  output flash_host_pkg::fdata_t dout,
  // injected supply fault
  input wire logic vlow_in
);
  import flash_host_pkg::*;
  fdata_t mem [faddr_t];
  fdata_t pd = 16'h0000, last = 16'h0000, rdv = 16'h0000;
  faddr_t pa = 22'h000000;
  logic busy = 1'b0, susp = 1'b0, tog = 1'b0, fail = 1'b0, ident = 1'b0, query = 1'b0, locked = 1'b0;
  logic [2:0] seq = 3'h0;
  int left = 0;
  ////////////////////////////////////////////////////////////////
  always @(posedge we_b)
  begin
    if (!ce_b && oe_b)
    begin
      // a data word inside a sequence must never be taken for a one-write command
      if (seq == 3'h3)
      begin
        // protected sector: nothing stored, failure flag up
        {pa, pd, busy, fail, left, seq} = {a, din, 1'b1, a[21], BUSY_READS, 3'h0};
      end
      else if (seq == 3'h4)
      begin
        locked |= !din[1];
        seq = 3'h0;
      end
      else if (din[7:0] == 8'hF0)
        {ident, query, busy, fail, seq} = '0;
      else if (din[7:0] == 8'hB0 && busy)
        susp = 1'b1;
      else if (din[7:0] == 8'h30 && susp)
        susp = 1'b0;
      else if (a == 22'h000055 && din[7:0] == 8'h98)
        query = 1'b1;
      else if (seq == 3'h0)
        seq = (a == 22'h000555 && din == 16'h00AA) ? 3'h1 : 3'h0;
      else if (seq == 3'h1)
        seq = (a == 22'h000AAA && din == 16'h0055) ? 3'h2 : 3'h0;
      else
      begin
        ident |= (din == 16'h0090);
        seq = (din == 16'h00A0) ? 3'h3 : (din == 16'h00C0) ? 3'h4 : 3'h0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  always @(negedge oe_b)
  begin
    if (!ce_b)
    begin
      if (ident)
        rdv = {14'h0000, !locked, 1'b0};
      else if (busy && !susp)
      begin
        // limitation: no erase and configuration stays 00, so erase and low-while-busy forms never show
        tog = !tog;
        rdv = {pd[15:8], !pd[7], tog, fail, 1'b0, vlow_in, 3'h0};
        if (left > 0)
          left--;
        else if (!fail && !vlow_in)
          {busy, mem[pa]} = {1'b0, pd};
      end
      else
        rdv = mem.exists(a) ? mem[a] : 16'hFFFF;
      last = rdv;
    end
  end
  // no pull on the data lines, so a released bus must not look like held data
  assign dout = (!ce_b && !oe_b) ? rdv : ~last;
endmodule : flash_dev_model

// File: flash_host.sv
// Purpose: host controller for a parallel NOR flash status, suspend and protection commands
// Assumes: software register port, one core clock, flash pins asynchronous
// Notes: rules of the host side and of the flash it drives follow
// What this block does
// - after failure the host must send the identification-mode leave command.
// - supply-low line high means supply too low; host then leaves with exit.
// - during erase suspend, reads and programs allowed; host starts no erase.
// - host resumes a suspended erase with one resume write.
// - lock uses four writes with lock bit zero in the fourth.
// - read protection after identification entry, then send exit before anything other than a query.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
// the parameter default below needs the timing counts before the header opens
`include "flash_host_map.svh"
module flash_host
  import flash_host_pkg::*;
#(
  parameter int unsigned PWR_CYCLES = `PWR_DELAY_CYC
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // software register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // flash pins
  output flash_host_pkg::faddr_t f_addr,
  output logic f_ce_b,
  output logic f_oe_b,
  output logic f_we_b,
  output flash_host_pkg::fdata_t f_dq_o,
  output logic f_dq_oe,
  input wire flash_host_pkg::fdata_t f_dq_i
);
  import flash_host_pkg::*;

  host_regs_t q, d;
  logic [1:0] rst_q;
  logic rst_s_b;
  flash_cyc_if cyc ();

  ////////////////////////////////////////////////////////////////////////////
  // decoding shared by acceptance and sequencing

  function automatic logic [1:0] seq_last(input cmd_t c);
    case (c)
      `CMD_PROGRAM, `CMD_LOCK: seq_last = 2'h3;
      `CMD_ID_ENTER: seq_last = 2'h2;
      default: seq_last = 2'h0;
    endcase
  endfunction : seq_last

  // one bus write of a command sequence: {address, data}
  function automatic logic [37:0] seq_word(input cmd_t c, input logic [1:0] i, input faddr_t a, input fdata_t w);
    seq_word = {a, w};
    case (c)
      `CMD_SUSPEND: seq_word = {a, `FD_SUSPEND};
      `CMD_RESUME: seq_word = {a, `FD_RESUME};
      `CMD_ID_EXIT, `CMD_AUTO_EXIT: seq_word = {a, `FD_ID_EXIT};
      `CMD_QUERY: seq_word = {`FA_QUERY, `FD_QUERY};
      default:
      begin
        case (i)
          2'h0: seq_word = {`FA_UNLOCK1, `FD_UNLOCK1};
          2'h1: seq_word = {`FA_UNLOCK2, `FD_UNLOCK2};
          2'h2:
          begin
            if (c == `CMD_ID_ENTER)
              seq_word = {`FA_UNLOCK1, `FD_ID_ENTER};
            else if (c == `CMD_LOCK)
              seq_word = {`FA_UNLOCK1, `FD_PROT};
            else
              seq_word = {`FA_UNLOCK1, `FD_PROGRAM};
          end
          default:
          begin
            if (c == `CMD_LOCK)
              seq_word = {a, w & `FD_LOCK_MASK};
            else
              seq_word = {a, w};
          end
        endcase
      end
    endcase
  endfunction : seq_word

  function automatic logic cmd_ok(input cmd_t c, input host_regs_t s);
    cmd_ok = 1'b0;
    if (!s.pwr_ok)
      cmd_ok = 1'b0;
    else if (s.fail || s.vlow)
      cmd_ok = (c == `CMD_ID_EXIT);
    else if (s.ident || s.query)
      cmd_ok = (c == `CMD_READ) || (c == `CMD_ID_EXIT) || (c == `CMD_QUERY && s.ident);
    else
    begin
      case (c)
        `CMD_READ, `CMD_POLL, `CMD_ID_ENTER, `CMD_ID_EXIT, `CMD_QUERY, `CMD_LOCK: cmd_ok = 1'b1;
        `CMD_PROGRAM: cmd_ok = !s.op_active || (s.susp && s.erase_kind);
        `CMD_SUSPEND: cmd_ok = s.op_active && !s.susp;
        `CMD_RESUME: cmd_ok = s.susp;
        default: cmd_ok = 1'b0;
      endcase
    end
  endfunction : cmd_ok

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_s_b = rst_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // register port and command sequencer

  always_comb
  begin
    d = q;
    d.req = 1'b0;
    d.rdata = 32'h0;
    if (reg_rd)
    begin
      case (reg_addr)
        `REG_ADDR: d.rdata = {10'h000, q.addr};
        `REG_WDATA: d.rdata = {16'h0000, q.wdata};
        `REG_RDATA: d.rdata = {16'h0000, q.rd_data};
        `REG_STATUS:
        begin
          d.rdata[`ST_BUSY] = (q.st != S_IDLE);
          d.rdata[`ST_PWR_OK] = q.pwr_ok;
          d.rdata[`ST_OP_ACTIVE] = q.op_active;
          d.rdata[`ST_SUSP] = q.susp;
          d.rdata[`ST_IDENT] = q.ident;
          d.rdata[`ST_QUERY] = q.query;
          d.rdata[`ST_FAIL] = q.fail;
          d.rdata[`ST_VLOW] = q.vlow;
          d.rdata[`ST_REFUSED] = q.refused;
          d.rdata[`ST_POLL_DONE] = q.poll_done;
        end
        default: d.rdata = 32'h0;
      endcase
    end
    if (reg_wr && reg_addr == `REG_ADDR)
      d.addr = reg_wdata[21:0];
    if (reg_wr && reg_addr == `REG_WDATA)
      d.wdata = reg_wdata[15:0];
    if (reg_wr && reg_addr == `REG_STATUS && reg_wdata[`ST_REFUSED])
      d.refused = 1'b0;
    // a refused command set in the same cycle still wins below
    if (reg_wr && reg_addr == `REG_CTRL && (q.st != S_IDLE || !cmd_ok(reg_wdata[3:0], q)))
      d.refused = 1'b1;
    case (q.st)
      S_PWR:
      begin
        d.cnt = q.cnt + 17'h00001;
        if (q.cnt >= 17'(PWR_CYCLES - 1))
        begin
          d.pwr_ok = 1'b1;
          d.st = S_IDLE;
        end
      end
      S_IDLE:
      begin
        if (reg_wr && reg_addr == `REG_CTRL && cmd_ok(reg_wdata[3:0], q))
        begin
          d.cmd = reg_wdata[3:0];
          d.idx = 2'h0;
          d.ph = 2'h0;
          if (reg_wdata[3:0] == `CMD_SUSPEND)
            d.erase_kind = reg_wdata[`CTRL_KIND_BIT];
          if (reg_wdata[3:0] == `CMD_POLL)
            d.poll_done = 1'b0;
          d.st = (reg_wdata[3:0] == `CMD_READ || reg_wdata[3:0] == `CMD_POLL) ? S_RD_ISSUE : S_ISSUE;
        end
      end
      S_ISSUE:
      begin
        d.req = 1'b1;
        d.req_wr = 1'b1;
        {d.req_addr, d.req_data} = seq_word(q.cmd, q.idx, q.addr, q.wdata);
        d.st = S_WAIT;
      end
      S_WAIT:
      begin
        if (cyc.done)
        begin
          d.st = S_IDLE;
          if (q.idx != seq_last(q.cmd))
          begin
            d.idx = q.idx + 2'h1;
            d.st = S_ISSUE;
          end
          else
          begin
            case (q.cmd)
              `CMD_PROGRAM:
              begin
                d.op_active = 1'b1;
                d.poll_done = 1'b0;
              end
              `CMD_SUSPEND:
              begin
                // wait the halt time of the suspended kind, erase or program, before reporting suspended
                d.cnt = q.erase_kind ? 17'(`SUSP_ERASE_CYC) : 17'(`SUSP_PROG_CYC);
                d.st = S_SUSP;
              end
              `CMD_RESUME: d.susp = 1'b0;
              `CMD_ID_ENTER: d.ident = 1'b1;
              `CMD_QUERY: d.query = 1'b1;
              `CMD_ID_EXIT:
              begin
                d.ident = 1'b0;
                d.query = 1'b0;
                d.fail = 1'b0;
                d.vlow = 1'b0;
              end
              // automatic exit keeps the flags so software still sees why
              `CMD_AUTO_EXIT:
              begin
                d.ident = 1'b0;
                d.query = 1'b0;
              end
              default: d.st = S_IDLE;
            endcase
          end
        end
      end
      S_RD_ISSUE:
      begin
        d.req = 1'b1;
        d.req_wr = 1'b0;
        d.req_addr = q.addr;
        d.st = S_RD_WAIT;
      end
      S_RD_WAIT:
      begin
        if (cyc.done)
        begin
          d.rd_data = cyc.rdata;
          d.st = S_IDLE;
          if (q.cmd == `CMD_POLL)
          begin
            if (!q.ph[0])
            begin
              d.first = cyc.rdata;
              d.ph = q.ph + 2'h1;
              d.st = S_RD_ISSUE;
            end
            else if (q.first[`DQ_TOGGLE] == cyc.rdata[`DQ_TOGGLE])
            begin
              d.op_active = 1'b0;
              d.poll_done = 1'b1;
            end
            else if (q.ph == 2'h1 && (cyc.rdata[`DQ_FAIL] || cyc.rdata[`DQ_VLOW]))
            begin
              // toggle may stop just as the flags rise: read twice more
              d.ph = 2'h2;
              d.st = S_RD_ISSUE;
            end
            else if (q.ph == 2'h3)
            begin
              d.fail = cyc.rdata[`DQ_FAIL];
              d.vlow = cyc.rdata[`DQ_VLOW];
              d.op_active = 1'b0;
              d.cmd = `CMD_AUTO_EXIT;
              d.idx = 2'h0;
              d.st = S_ISSUE;
            end
          end
        end
      end
      S_SUSP:
      begin
        d.cnt = q.cnt - 17'h00001;
        if (q.cnt == 17'h00000)
        begin
          d.susp = 1'b1;
          d.st = S_IDLE;
        end
      end
      default: d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_s_b)
  begin
    if (!rst_s_b)
    begin
      q <= '0;
      q.st <= S_PWR;
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign cyc.req = q.req;
  assign cyc.wr = q.req_wr;
  assign cyc.addr = q.req_addr;
  assign cyc.wdata = q.req_data;

  flash_bus_cycle u_cycle (
    .core_clk(core_clk),
    .rst_sync_b(rst_s_b),
    .cyc(cyc.eng),
    .f_addr(f_addr),
    .f_ce_b(f_ce_b),
    .f_oe_b(f_oe_b),
    .f_we_b(f_we_b),
    .f_dq_o(f_dq_o),
    .f_dq_oe(f_dq_oe),
    .f_dq_i(f_dq_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [7:0] susp_cyc;
  always_ff @(posedge core_clk or negedge rst_s_b)
  begin
    if (!rst_s_b)
      susp_cyc <= 8'h00;
    else if (q.st != S_SUSP)
      susp_cyc <= 8'h00;
    else if (susp_cyc != 8'hFF)
      susp_cyc <= susp_cyc + 8'h01;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_s_b);

  sequence exit_write_s;
    ##1 q.req && q.req_wr && q.req_data == `FD_ID_EXIT;
  endsequence

  chk_pwr_no_write: assert property (!q.pwr_ok |-> !q.req)
    else $error("flash access before power-up delay");
  chk_fail_exit: assert property ($rose(q.fail) || $rose(q.vlow) |-> exit_write_s)
    else $error("no exit command after failure flag");
  chk_lock_bit: assert property (q.req && q.req_wr && q.cmd == `CMD_LOCK && q.idx == 2'h3
    |-> !q.req_data[`DQ_LOCK])
    else $error("lock write with lock bit high");
  chk_ident_only: assert property (q.ident && q.req && q.req_wr
    |-> q.req_data == `FD_ID_EXIT || q.req_data == `FD_QUERY)
    else $error("operation started while in identification mode");
  chk_resume_single: assert property (q.st == S_WAIT && q.cmd == `CMD_RESUME && cyc.done
    |=> !q.susp && q.st == S_IDLE)
    else $error("resume did not finish in one write");
  chk_susp_wait: assert property ($rose(q.susp) |-> $past(susp_cyc) >= 8'(`SUSP_PROG_CYC))
    else $error("suspended reported before halt time");
  chk_query_word: assert property (q.req && q.req_wr && q.cmd == `CMD_QUERY |-> q.req_addr == `FA_QUERY)
    else $error("query command at wrong address");
  chk_poll_stop: assert property (q.st == S_RD_WAIT && cyc.done && q.cmd == `CMD_POLL && q.ph[0]
    && q.first[`DQ_TOGGLE] == cyc.rdata[`DQ_TOGGLE] |=> !q.op_active && q.poll_done)
    else $error("poll did not end when toggle stopped");
  chk_rdata_once: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data stood beyond one cycle");
endmodule : flash_host

// File: flash_host_map.svh
// Purpose: offsets, field positions, flash command words and timing counts
// Assumes: core_clk at 10 MHz
// Notes: included by the host controller and its bus cycle engine
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

// software register offsets
`define REG_CTRL 5'h00
`define REG_ADDR 5'h04
`define REG_WDATA 5'h08
`define REG_STATUS 5'h0C
`define REG_RDATA 5'h10

// control word fields
`define CTRL_KIND_BIT 4

// status bits
`define ST_BUSY 0
`define ST_PWR_OK 1
`define ST_OP_ACTIVE 2
`define ST_SUSP 3
`define ST_IDENT 4
`define ST_QUERY 5
`define ST_FAIL 6
`define ST_VLOW 7
`define ST_REFUSED 8
`define ST_POLL_DONE 9

// software command codes; 4'hF is the host's own exit and is refused from software
`define CMD_READ 4'h1
`define CMD_PROGRAM 4'h2
`define CMD_SUSPEND 4'h3
`define CMD_RESUME 4'h4
`define CMD_ID_ENTER 4'h5
`define CMD_ID_EXIT 4'h6
`define CMD_QUERY 4'h7
`define CMD_LOCK 4'h8
`define CMD_POLL 4'h9
`define CMD_AUTO_EXIT 4'hF

// flash bus words
`define FA_UNLOCK1 22'h000555
`define FA_UNLOCK2 22'h000AAA
`define FA_QUERY 22'h000055
`define FD_UNLOCK1 16'h00AA
`define FD_UNLOCK2 16'h0055
`define FD_PROGRAM 16'h00A0
`define FD_SUSPEND 16'h00B0
`define FD_RESUME 16'h0030
`define FD_ID_ENTER 16'h0090
`define FD_ID_EXIT 16'h00F0
`define FD_QUERY 16'h0098
`define FD_PROT 16'h00C0
`define FD_LOCK_MASK 16'hFFFD

// data line positions
`define DQ_POLL 7
`define DQ_TOGGLE 6
`define DQ_FAIL 5
`define DQ_VLOW 3
`define DQ_LOCK 1

// timing
`define CLK_MHZ 10
`define PWR_DELAY_MS 10
`define SUSP_ERASE_US 15
`define SUSP_PROG_US 10
`define PWR_DELAY_CYC (`PWR_DELAY_MS * 1000 * `CLK_MHZ)
`define SUSP_ERASE_CYC (`SUSP_ERASE_US * `CLK_MHZ)
`define SUSP_PROG_CYC (`SUSP_PROG_US * `CLK_MHZ)
`define RD_WAIT_LAST 2'h3

`endif

// File: flash_host_pkg.sv
// Purpose: types shared by the flash host controller files
// Assumes: nothing
// Notes: state of the host and of the bus cycle engine is one packed struct each
package flash_host_pkg;
  typedef logic [21:0] faddr_t;
  typedef logic [15:0] fdata_t;
  typedef logic [3:0] cmd_t;
  typedef enum logic [2:0] {S_PWR, S_IDLE, S_ISSUE, S_WAIT, S_RD_ISSUE, S_RD_WAIT, S_SUSP} host_state_t;
  typedef enum logic [2:0] {C_IDLE, C_W_LOW, C_W_HIGH, C_W_END, C_R_WAIT} cyc_state_t;
  typedef struct packed {
    host_state_t st;
    logic [16:0] cnt;
    logic pwr_ok;
    cmd_t cmd;
    logic erase_kind;
    logic [1:0] idx;
    logic [1:0] ph;
    faddr_t addr;
    fdata_t wdata;
    fdata_t first;
    fdata_t rd_data;
    logic op_active;
    logic susp;
    logic ident;
    logic query;
    logic fail;
    logic vlow;
    logic refused;
    logic poll_done;
    logic req;
    logic req_wr;
    faddr_t req_addr;
    fdata_t req_data;
    logic [31:0] rdata;
  } host_regs_t;
  typedef struct packed {
    cyc_state_t st;
    logic [1:0] cnt;
    logic ce_b;
    logic oe_b;
    logic we_b;
    faddr_t a;
    fdata_t dq_o;
    logic dq_oe;
    fdata_t s1;
    fdata_t s2;
    logic done;
    fdata_t rdata;
  } cyc_regs_t;
endpackage : flash_host_pkg

// File: tb.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: power-up wait shortened to 20 cycles
// Notes: flash side is the behavioural device model
`timescale 1ns/100ps
`include "flash_host_map.svh"
module tb;
  import flash_host_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic vlow_in = 1'b0;
  logic [31:0] reg_rdata, st, rv;
  logic [31:0] rnd_q = 32'h1;
  faddr_t f_addr;
  fdata_t f_dq_o, f_dq_i, m_dq;
  logic f_ce_b, f_oe_b, f_we_b, f_dq_oe;
  int errors = 0;
  int tests_run = 0;
  assign f_dq_i = f_dq_oe ? f_dq_o : m_dq;
  flash_host #(.PWR_CYCLES(20)) i_dut (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .f_addr, .f_ce_b, .f_oe_b, .f_we_b, .f_dq_o, .f_dq_oe, .f_dq_i);
  flash_dev_model i_dev (.a(f_addr), .ce_b(f_ce_b), .oe_b(f_oe_b), .we_b(f_we_b), .din(f_dq_o), .dout(m_dq),
    .vlow_in(vlow_in));
  initial forever #50 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [31:0] ident_word(input logic lk);
    return {30'h0, !lk, 1'b0};
  endfunction : ident_word
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask : rd
  task automatic cmd(input logic [31:0] c);
    int n;
    wr(`REG_CTRL, c);
    for (n = 0; n < 400; n++)
    begin
      rd(`REG_STATUS, st);
      if (st[`ST_BUSY] === 1'b0)
        return;
    end
    errors++;
    end_of_test();
  endtask : cmd
  task automatic poll();
    int n;
    for (n = 0; n < 20; n++)
    begin
      cmd(`CMD_POLL);
      if ((!st[`ST_OP_ACTIVE] | st[`ST_FAIL] | st[`ST_VLOW]) === 1'b1)
        return;
    end
    // an operation that never ends is a hang, not a pass
    errors++;
    end_of_test();
  endtask : poll
  task automatic prog(input faddr_t a, input fdata_t d);
    wr(`REG_ADDR, a);
    wr(`REG_WDATA, d);
    cmd(`CMD_PROGRAM);
  endtask : prog
  ////////////////////////////////////////////////////////////////
  initial
  begin
    faddr_t a0;
    fdata_t d0;
    int k;
    repeat (5) @(posedge core_clk);
    chk("select idle in reset", f_ce_b, 1'b1);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    wr(`REG_CTRL, `CMD_READ);
    rd(`REG_STATUS, st);
    chk("early command refused", st[`ST_REFUSED], 1'b1);
    repeat (30) @(posedge core_clk);
    wr(`REG_STATUS, 32'h100);
    $display("test power delay done");
    for (k = 0; k < 3; k++)
    begin
      rnd_q = xs(rnd_q);
      {a0, d0} = {1'b0, rnd_q[20:0], rnd_q[31:16]};
      prog(a0, d0);
      poll();
      chk("poll done", st[`ST_POLL_DONE], 1'b1);
      chk("stored word", i_dev.mem[a0], d0);
      cmd(`CMD_READ);
      rd(`REG_RDATA, rv);
      chk("read back", rv[15:0], d0);
    end
    $display("test program and poll done");
    for (k = 0; k < 2; k++)
    begin
      prog(22'h001000 + 22'(k), 16'h5A5A);
      cmd({27'h0, k[0], `CMD_SUSPEND});
      chk("suspended", st[`ST_SUSP], 1'b1);
      chk("device suspended", i_dev.susp, 1'b1);
      wr(`REG_ADDR, a0);
      cmd(`CMD_READ);
      rd(`REG_RDATA, rv);
      chk("read in suspend", rv[15:0], d0);
      cmd(`CMD_PROGRAM);
      chk("program in suspend", st[`ST_REFUSED], k == 0);
      wr(`REG_STATUS, 32'h100);
      cmd(`CMD_RESUME);
      chk("device resumed", i_dev.susp, 1'b0);
      poll();
      chk("resume finishes", st[`ST_OP_ACTIVE], 1'b0);
    end
    $display("test suspend done");
    prog(22'h200042, 16'h0000);
    poll();
    chk("fail flag", st[`ST_FAIL], 1'b1);
    chk("protected untouched", i_dev.mem.exists(22'h200042), 1'b0);
    cmd(`CMD_READ);
    chk("read after fail", st[`ST_REFUSED], 1'b1);
    cmd(`CMD_ID_EXIT);
    chk("fail cleared", st[`ST_FAIL], 1'b0);
    wr(`REG_STATUS, 32'h100);
    vlow_in <= 1'b1;
    prog(22'h002000, 16'h1234);
    poll();
    chk("supply low flag", st[`ST_VLOW], 1'b1);
    cmd(`CMD_ID_EXIT);
    chk("supply flag cleared", st[`ST_VLOW], 1'b0);
    vlow_in <= 1'b0;
    $display("test failure flags done");
    for (k = 0; k < 2; k++)
    begin
      cmd(`CMD_ID_ENTER);
      chk("ident mode", st[`ST_IDENT], 1'b1);
      cmd(`CMD_READ);
      rd(`REG_RDATA, rv);
      chk("lock state", rv, ident_word(k[0]));
      cmd(`CMD_QUERY);
      chk("query mode", st[`ST_QUERY] & i_dev.query, 1'b1);
      cmd(`CMD_ID_EXIT);
      chk("query left", st[`ST_QUERY] | i_dev.query, 1'b0);
      rnd_q = xs(rnd_q);
      wr(`REG_WDATA, rnd_q);
      cmd(`CMD_LOCK);
      chk("locked", i_dev.locked, 1'b1);
    end
    $display("test protection done");
    end_of_test();
  end
endmodule : tb
